/* File: rtl/bru_pkg.sv */
// Package: constants, opcodes, states and carriers of the byte rotate unit
package bru_pkg;
   localparam logic [7:0] OPC_ROT_LEFT_REG = 8'h90;
   localparam logic [7:0] OPC_ROT_LEFT_IND = 8'h91;
   localparam logic [7:0] OPC_ROT_LEFT_CARRY_REG = 8'h10;
   localparam logic [7:0] OPC_ROT_LEFT_CARRY_IND = 8'h11;
   localparam logic [7:0] OPC_ROT_RIGHT_REG = 8'he0;
   localparam logic [7:0] OPC_ROT_RIGHT_IND = 8'he1;
   localparam int MSB_POS = 7;
   localparam int LSB_POS = 0;
   localparam int FLAG_C = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 5;
   localparam int FLAG_V = 4;
   localparam int FLAG_D = 3;
   localparam int FLAG_H = 2;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam int INSTR_CYCLES = 4;
   localparam int INSTR_BYTES = 2;

   typedef enum logic [1:0] {
      BRU_OP_ROTATE_LEFT = 2'h0,
      BRU_OP_ROTATE_LEFT_CARRY = 2'h1,
      BRU_OP_ROTATE_RIGHT = 2'h2
   } bru_op_type;

   typedef enum logic [3:0] {
      BRU_ST_IDLE = 4'h1,
      BRU_ST_POINTER = 4'h2,
      BRU_ST_OPERAND = 4'h4,
      BRU_ST_WRITE = 4'h8
   } bru_state_type;

   // Instruction handed over by the decoder: opcode and operand byte
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] dst;
   } bru_instr_type;

   // Register file access requested by the unit
   typedef struct packed {
      logic rd_en;
      logic wr_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bru_rf_type;
endpackage

/* File: rtl/bru_rotate.sv */
// Combinational rotate core: result byte and updated flags
`timescale 1ns/1ps
module bru_rotate (
   input wire bru_pkg::bru_op_type op_in,
   input wire logic [7:0] operand_in,
   input wire logic [7:0] flags_in,
   output logic [7:0] result_out,
   output logic [7:0] flags_out
);
   import bru_pkg::*;

   wire logic [7:0] rot_left = {operand_in[6:0], operand_in[MSB_POS]};
   wire logic [7:0] rot_left_c = {operand_in[6:0], flags_in[FLAG_C]};
   wire logic [7:0] rot_right = {operand_in[LSB_POS], operand_in[7:1]};
   wire logic carry_new = (op_in == BRU_OP_ROTATE_RIGHT) ? operand_in[LSB_POS]
                                                         : operand_in[MSB_POS];
   wire logic [7:0] res = (op_in == BRU_OP_ROTATE_RIGHT) ? rot_right :
                          (op_in == BRU_OP_ROTATE_LEFT_CARRY) ? rot_left_c : rot_left;

   assign result_out = res;
   always_comb begin
      flags_out = flags_in; // D, H and the low bits stay as they were
      flags_out[FLAG_C] = carry_new;
      flags_out[FLAG_Z] = (res == BYTE_ZERO);
      flags_out[FLAG_S] = res[MSB_POS];
      flags_out[FLAG_V] = res[MSB_POS] ^ operand_in[MSB_POS];
   end
endmodule

/* File: rtl/bru_top.sv */
// Byte rotate unit: decode, operand fetch, rotate and write-back sequencer
`timescale 1ns/1ps
// Notes on behaviour
// - Rotate left: bit 7 to bit 0 and carry
// - Rotate through carry: old carry enters bit 0
// - Rotate right: bit 0 to bit 7 and carry
// - Left rotates: carry equals original bit 7
// - Right rotate: carry equals original bit 0
// - Zero flag set when result is zero
// - Sign flag copies result bit 7
// - Overflow on sign change; D, H untouched
module bru_top (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire bru_pkg::bru_instr_type instr_in,
   input wire logic [7:0] rf_rdata_in,
   input wire logic [7:0] flags_in,
   output logic busy_out,
   output logic done_out,
   output logic illegal_out,
   output bru_pkg::bru_rf_type rf_out,
   output logic flags_we_out,
   output logic [7:0] flags_out
);
   import bru_pkg::*;

   // ****************************************
   // Decode
   // ****************************************
   wire logic is_rot_left = (instr_in.opcode == OPC_ROT_LEFT_REG) ||
                            (instr_in.opcode == OPC_ROT_LEFT_IND);
   wire logic is_rot_left_carry = (instr_in.opcode == OPC_ROT_LEFT_CARRY_REG) ||
                                  (instr_in.opcode == OPC_ROT_LEFT_CARRY_IND);
   wire logic is_rot_right = (instr_in.opcode == OPC_ROT_RIGHT_REG) ||
                             (instr_in.opcode == OPC_ROT_RIGHT_IND);
   wire logic legal = is_rot_left || is_rot_left_carry || is_rot_right;
   wire logic is_ind = instr_in.opcode[0]; // Odd code picks indirect mode
   wire bru_op_type dec_op = is_rot_right ? BRU_OP_ROTATE_RIGHT :
                             is_rot_left_carry ? BRU_OP_ROTATE_LEFT_CARRY : BRU_OP_ROTATE_LEFT;

   // ****************************************
   // State
   // ****************************************
   bru_state_type state_q, state_d;
   bru_op_type op_q;
   logic ind_q;
   logic [7:0] addr_q, addr_d;
   logic [7:0] operand_q;
   logic [7:0] flags_snap_q;
   logic busy_q, done_q, illegal_q, flags_we_q;
   logic [7:0] flags_q;
   bru_rf_type rf_q, rf_d;
   wire logic [7:0] rot_result;
   wire logic [7:0] rot_flags;

   bru_rotate u_rotate (
      .op_in(op_q),
      .operand_in(operand_q),
      .flags_in(flags_snap_q),
      .result_out(rot_result),
      .flags_out(rot_flags)
   );

   // ****************************************
   // Sequencer decode
   // ****************************************
   wire logic in_idle = (state_q == BRU_ST_IDLE);
   wire logic in_pointer = (state_q == BRU_ST_POINTER);
   wire logic in_operand = (state_q == BRU_ST_OPERAND);
   wire logic in_write = (state_q == BRU_ST_WRITE);
   wire logic next_idle = (state_d == BRU_ST_IDLE);
   wire logic accept = start_in && legal && in_idle;
   // Starts while busy are dropped silently; only an idle start is judged
   wire logic illegal_start = start_in && !legal && in_idle;
   // Direct mode has its operand one cycle earlier than indirect mode
   wire logic cap_direct = in_pointer && !ind_q;
   wire logic cap_indirect = in_operand && ind_q;

   // Every form walks idle, pointer, operand, write: four cycles
   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      rf_d = '0;
      case (state_q)
         BRU_ST_IDLE: begin
            if (accept) begin
               state_d = BRU_ST_POINTER;
               addr_d = instr_in.dst;
               rf_d.rd_en = 1'b1;
               rf_d.addr = instr_in.dst;
            end
         end
         BRU_ST_POINTER: begin
            state_d = BRU_ST_OPERAND;
            // Pointer is only read, never written back
            if (ind_q) begin
               addr_d = rf_rdata_in;
               rf_d.rd_en = 1'b1;
               rf_d.addr = rf_rdata_in;
            end
         end
         BRU_ST_OPERAND: begin
            state_d = BRU_ST_WRITE;
         end
         BRU_ST_WRITE: begin
            state_d = BRU_ST_IDLE;
            rf_d.wr_en = 1'b1;
            rf_d.addr = addr_q; // pointed location in indirect mode
            rf_d.wdata = rot_result;
         end
         default: begin
            state_d = BRU_ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // Registers
   // ****************************************
   // Sequencer state
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= BRU_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Write-back address: the pointed location in indirect mode
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         addr_q <= BYTE_ZERO;
      end else begin
         addr_q <= addr_d;
      end
   end

   // Register file strobes are registered so the outputs come from flops
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rf_q <= '0;
      end else begin
         rf_q <= rf_d;
      end
   end

   // Operation and mode are held for the whole instruction
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         op_q <= BRU_OP_ROTATE_LEFT;
      end else if (accept) begin
         op_q <= dec_op;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ind_q <= 1'b0;
      end else if (accept) begin
         ind_q <= is_ind;
      end
   end

   // Read data is combinational, so it is taken in the cycle its strobe stands
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         operand_q <= BYTE_ZERO;
      end else if (cap_direct || cap_indirect) begin
         operand_q <= rf_rdata_in;
      end
   end

   // Flags sampled at issue; a later flags write cannot leak into this result
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         flags_snap_q <= BYTE_ZERO;
      end else if (accept) begin
         flags_snap_q <= flags_in; // Carry feeds bit 0
      end
   end

   // ****************************************
   // Completion
   // ****************************************
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= !next_idle;
      end
   end

   // Done, flags strobe and write strobe rise together
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         done_q <= 1'b0;
      end else begin
         done_q <= in_write;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         flags_we_q <= 1'b0;
      end else begin
         flags_we_q <= in_write;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         illegal_q <= 1'b0;
      end else begin
         illegal_q <= illegal_start;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         flags_q <= BYTE_ZERO;
      end else if (in_write) begin
         flags_q <= rot_flags;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign busy_out = busy_q;
   assign done_out = done_q;
   assign illegal_out = illegal_q;
   assign rf_out = rf_q;
   assign flags_we_out = flags_we_q;
   assign flags_out = flags_q;
endmodule

/* File: verif/bru_props.sv */
// Checker: timing and flag relations at the rotate unit ports
`timescale 1ns/1ps
module bru_props (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire bru_pkg::bru_instr_type instr_in,
   input wire logic [7:0] rf_rdata_in,
   input wire logic [7:0] flags_in,
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic illegal_out,
   input wire bru_pkg::bru_rf_type rf_out,
   input wire logic flags_we_out,
   input wire logic [7:0] flags_out
);
   import bru_pkg::*;
   wire logic [7:0] opc = instr_in.opcode;
   wire logic [7:0] even_opc = {opc[7:1], 1'b0};
   wire logic is_left = (even_opc == OPC_ROT_LEFT_REG);
   wire logic is_left_carry = (even_opc == OPC_ROT_LEFT_CARRY_REG);
   wire logic is_right = (even_opc == OPC_ROT_RIGHT_REG);
   wire logic is_legal = is_left || is_left_carry || is_right;
   // Only starts from idle count; starts while busy are ignored
   wire logic acc = start_in && !busy_out && is_legal;
   wire logic [7:0] wd = rf_out.wdata;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   done_latency_a: assert property (acc |-> ##4 done_out)
      else $error("done not four cycles after issue");
   done_writes_a: assert property (done_out |-> flags_we_out && rf_out.wr_en)
      else $error("done without write strobes");
   zero_flag_a: assert property (flags_we_out |-> flags_out[FLAG_Z] == (wd == BYTE_ZERO))
      else $error("zero flag wrong");
   sign_flag_a: assert property (flags_we_out |-> flags_out[FLAG_S] == wd[7])
      else $error("sign flag wrong");
   keep_dh_a: assert property (acc |-> ##4 flags_out[3:0] == $past(flags_in[3:0], 4))
      else $error("untouched flags changed");
   left_carry_a: assert property (acc && is_left |-> ##4 flags_out[FLAG_C] == wd[0])
      else $error("left carry wrong");
   right_carry_a: assert property (acc && is_right |-> ##4 flags_out[FLAG_C] == wd[7])
      else $error("right carry wrong");
   carry_in_a: assert property (acc && is_left_carry |-> ##4 wd[0] == $past(flags_in[7], 4))
      else $error("carry not rotated in");
   right_ovf_a: assert property (acc && is_right |-> ##4 flags_out[FLAG_V] == (wd[7] ^ wd[6]))
      else $error("right overflow wrong");
   left_ovf_a: assert property (acc && is_left |-> ##4 flags_out[FLAG_V] == (wd[7] ^ wd[0]))
      else $error("left overflow wrong");
   carry_ovf_a: assert property (acc && is_left_carry |->
      ##4 flags_out[FLAG_V] == (wd[7] ^ flags_out[FLAG_C]))
      else $error("carry rotate overflow wrong");
   direct_addr_a: assert property (acc && !opc[0] |-> ##4 rf_out.addr == $past(instr_in.dst, 4))
      else $error("direct write address wrong");
   illegal_pulse_a: assert property (start_in && !busy_out && !is_legal |=> illegal_out)
      else $error("illegal opcode not flagged");
   done_c: cover property (done_out);
   ind_c: cover property (acc && instr_in.opcode[0]);
   ill_c: cover property (illegal_out);
endmodule

/* File: verif/bru_rf_model.sv */
// Register file model answering the unit's reads in the cycle they stand
`timescale 1ns/1ps
module bru_rf_model (
   input wire logic clk_in,
   input wire bru_pkg::bru_rf_type rf_in,
   output logic [7:0] rdata_out
);
   import bru_pkg::*;
   logic [7:0] mem [256];
   logic [7:0] idle_q = 8'h00;
   // Read is combinational: data stands while the read strobe stands
   assign rdata_out = rf_in.rd_en ? mem[rf_in.addr] : idle_q;
   // Idle cycles show a toggling pattern so a stale capture is seen
   always @(posedge clk_in) begin
      if (rf_in.wr_en) mem[rf_in.addr] <= rf_in.wdata;
      idle_q <= ~idle_q;
   end
endmodule

/* File: verif/byte_rotate_unit_tb_top.sv */
// Testbench: rotate scenarios against the register file model
`timescale 1ns/1ps
module byte_rotate_unit_tb_top;
   import bru_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic start_in = 1'b0;
   bru_instr_type instr_in = '0;
   logic [7:0] flags_in = 8'h00;
   logic [7:0] rf_rdata_in, flags_out;
   logic busy_out, done_out, illegal_out, flags_we_out;
   bru_rf_type rf_out;
   int mismatches = 0;
   int n_tests = 0;
   always #5 clk_in = ~clk_in;
   bru_top dut (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in), .instr_in(instr_in),
      .rf_rdata_in(rf_rdata_in), .flags_in(flags_in), .busy_out(busy_out), .done_out(done_out),
      .illegal_out(illegal_out), .rf_out(rf_out), .flags_we_out(flags_we_out),
      .flags_out(flags_out));
   bru_rf_model rf (.clk_in(clk_in), .rf_in(rf_out), .rdata_out(rf_rdata_in));
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic exec(logic [7:0] opc, dst, fl, res, adr, logic [3:0] czsv);
      int i;
      start_in = 1'b1;
      instr_in = {opc, dst};
      flags_in = fl;
      @(posedge clk_in);
      #1 start_in = 1'b0;
      check("issue", {6'h00, rf_out.rd_en, busy_out}, 8'h03);
      check("rdaddr", rf_out.addr, dst);
      for (i = 0; i < 6 && done_out !== 1'b1; i++) begin
         @(posedge clk_in);
         #1;
      end
      if (i == 6) begin
         mismatches++;
         results();
      end
      check("cycles", 8'(i + 1), 8'(INSTR_CYCLES));
      check("addr", rf_out.addr, adr);
      check("wdata", rf_out.wdata, res);
      check("flags", flags_out, {czsv, fl[3:0]});
      check("we", {6'h00, rf_out.wr_en, flags_we_out}, 8'h03);
      @(posedge clk_in);
      #1;
      check("busy", {7'h00, busy_out}, 8'h00);
      check("mem", rf.mem[adr], res);
   endtask
   task automatic t_rotate_left();
      rf.mem[0] = 8'haa;
      rf.mem[1] = 8'h02;
      rf.mem[2] = 8'h17;
      exec(OPC_ROT_LEFT_REG, 8'h00, 8'h0c, 8'h55, 8'h00, 4'b1001);
      exec(OPC_ROT_LEFT_IND, 8'h01, 8'h0f, 8'h2e, 8'h02, 4'b0000);
      check("ptr", rf.mem[1], 8'h02);
      $display("rotate left done");
   endtask
   task automatic t_rotate_left_carry();
      rf.mem[0] = 8'haa;
      rf.mem[2] = 8'h17;
      exec(OPC_ROT_LEFT_CARRY_REG, 8'h00, 8'h8c, 8'h55, 8'h00, 4'b1001);
      exec(OPC_ROT_LEFT_CARRY_IND, 8'h01, 8'h04, 8'h2e, 8'h02, 4'b0000);
      $display("rotate left carry done");
   endtask
   task automatic t_rotate_right();
      rf.mem[0] = 8'h31;
      rf.mem[2] = 8'h17;
      exec(OPC_ROT_RIGHT_REG, 8'h00, 8'h08, 8'h98, 8'h00, 4'b1011);
      exec(OPC_ROT_RIGHT_IND, 8'h01, 8'h00, 8'h8b, 8'h02, 4'b1011);
      check("ptr", rf.mem[1], 8'h02);
      $display("rotate right done");
   endtask
   task automatic t_zero_result();
      rf.mem[5] = 8'h00;
      exec(OPC_ROT_LEFT_REG, 8'h05, 8'hf0, 8'h00, 8'h05, 4'b0100);
      rf.mem[5] = 8'h80;
      exec(OPC_ROT_LEFT_CARRY_REG, 8'h05, 8'h03, 8'h00, 8'h05, 4'b1101);
      $display("zero result done");
   endtask
   task automatic t_illegal();
      start_in = 1'b1;
      instr_in = {8'hc0, 8'h00};
      @(posedge clk_in);
      #1 start_in = 1'b0;
      check("illegal", {7'h00, illegal_out}, 8'h01);
      repeat (4) @(posedge clk_in);
      #1;
      check("nowrite", {5'h00, illegal_out, rf_out.wr_en, busy_out}, 8'h00);
      $display("illegal opcode done");
   endtask
   task automatic t_reset();
      rf.mem[6] = 8'h81;
      start_in = 1'b1;
      instr_in = {OPC_ROT_LEFT_REG, 8'h06};
      flags_in = 8'h00;
      @(posedge clk_in);
      #1 start_in = 1'b0;
      @(posedge clk_in);
      #1 rst_in = 1'b1;
      @(posedge clk_in);
      #1;
      check("rst_rf", {6'h00, rf_out.rd_en, rf_out.wr_en}, 8'h00);
      check("rst_ctl", {4'h0, busy_out, done_out, illegal_out, flags_we_out}, 8'h00);
      check("rst_addr", rf_out.addr, 8'h00);
      check("rst_flags", flags_out, 8'h00);
      @(posedge clk_in);
      #1 rst_in = 1'b0;
      check("aborted", rf.mem[6], 8'h81);
      exec(OPC_ROT_RIGHT_REG, 8'h06, 8'h00, 8'hc0, 8'h06, 4'b1010);
      $display("mid-run reset done");
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      #1 rst_in = 1'b0;
      t_rotate_left();
      t_rotate_left_carry();
      t_rotate_right();
      t_zero_result();
      t_illegal();
      t_reset();
      results();
   end
endmodule
bind bru_top bru_props u_props (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
   .instr_in(instr_in), .rf_rdata_in(rf_rdata_in), .flags_in(flags_in), .busy_out(busy_out),
   .done_out(done_out), .illegal_out(illegal_out), .rf_out(rf_out),
   .flags_we_out(flags_we_out), .flags_out(flags_out));
